// [src/cdr_regs_pkg.sv]
/*
 * Constants for the transmit clock-recovery control and status register bank:
 * register numbers, field positions, reset values and code points.
 * Assumes register numbers are used directly as the 8-bit register address.
 */
// What this block does
// - Two-bit mode: auto, fixed 10.3G, fixed 11.1G, test.
// - Force-on bit keeps rate detector enabled unless force-off is also set.
// - Force-off bit keeps rate detector always disabled.
// - Quick-lock runs unless its disable bit is set.
// - Divider codes 000..101 give full rate to /32.
// - Converter result split: 9:2 high, 1:0 low.
// - Receive status bit 7 shows live unlock.
// - Receive bit 6 latches low until read.
// - Receive status bit 5 shows live signal loss.
// - Receive bit 4 latches loss high until read.
// - Transmit status bit 7 shows live unlock.
// - Transmit bit 6 latches low until read.
// - Transmit bit 5 shows live fault.
// - Transmit bit 4 shows driver shutoff.
// - Addresses 20-39 and 44-50 are reserved.
// - Adjustment register 51 resets to 40h.
package cdr_regs_pkg;

    localparam logic [7:0] ADDR_TX_CDR_CONTROL = 8'h13;
    localparam logic [7:0] ADDR_RSVD_A_FIRST = 8'h14;
    localparam logic [7:0] ADDR_RSVD_A_LAST = 8'h27;
    localparam logic [7:0] ADDR_ADC_RESULT_HIGH = 8'h28;
    localparam logic [7:0] ADDR_ADC_RESULT_LOW = 8'h29;
    localparam logic [7:0] ADDR_RECEIVE_STATUS = 8'h2A;
    localparam logic [7:0] ADDR_TRANSMIT_STATUS = 8'h2B;
    localparam logic [7:0] ADDR_RSVD_B_FIRST = 8'h2C;
    localparam logic [7:0] ADDR_RSVD_B_LAST = 8'h32;
    localparam logic [7:0] ADDR_LOOP_FILTER_ADJUST = 8'h33;
    localparam logic [7:0] ADDR_IRQ_STATUS = 8'h38;
    localparam logic [7:0] ADDR_IRQ_ENABLE = 8'h39;
    localparam logic [7:0] ADDR_IRQ_CLEAR = 8'h3A;

    localparam logic [7:0] TX_CDR_CONTROL_RESET = 8'h00;
    localparam logic [7:0] LOOP_FILTER_ADJUST_RESET = 8'h40;
    localparam logic [7:0] LOOP_FILTER_ADJUST_MASK = 8'hE0;

    // Control register field positions.
    localparam int CTL_MODE_HI = 7;
    localparam int CTL_MODE_LO = 6;
    localparam int CTL_FORCE_ON = 5;
    localparam int CTL_FORCE_OFF = 4;
    localparam int CTL_QUICK_LOCK_OFF = 3;
    localparam int CTL_DIV_HI = 2;
    localparam int CTL_DIV_LO = 0;

    // Status register field positions, shared by both paths.
    localparam int ST_UNLOCK_LIVE = 7;
    localparam int ST_LOCK_STICKY = 6;
    localparam int ST_BIT5 = 5;
    localparam int ST_BIT4 = 4;

    localparam int LF_RES_HI = 7;
    localparam int LF_RES_LO = 5;

    localparam logic [1:0] MODE_AUTO = 2'h0;
    localparam logic [1:0] MODE_FIXED_10G3 = 2'h1;
    localparam logic [1:0] MODE_FIXED_11G1 = 2'h2;
    localparam logic [1:0] MODE_TEST = 2'h3;

    localparam logic [2:0] DIV_LAST_CODE = 3'h5;

    // Interrupt event bit positions.
    localparam int IRQ_RX_UNLOCK = 0;
    localparam int IRQ_RX_LOSS = 1;
    localparam int IRQ_TX_UNLOCK = 2;
    localparam int IRQ_TX_FAULT = 3;
    localparam int IRQ_TX_SHUTOFF = 4;
    localparam int IRQ_COUNT = 5;

    localparam logic [4:0] IRQ_RESET = 5'h00;
    localparam logic [7:0] READ_ZERO = 8'h00;

endpackage

// [src/cdr_status_control_regs.sv]
/*
 * Register bank for transmit clock-recovery control, the split converter
 * result, receive and transmit status with read-clear latches, and a small
 * interrupt block. Assumes one 50 MHz clock, a plain strobe register port
 * driven from that clock, and status flags arriving asynchronously from pins.
 */
// Implementation choice: the strobed register port.
`timescale 1ns/10ps
`default_nettype none

module cdr_status_control_regs
    import cdr_regs_pkg::*;
(
    input wire logic sys_clk,
    input wire logic srst,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    input wire logic [9:0] adc_result,
    input wire logic rx_unlock_live,
    input wire logic rx_signal_loss_live,
    input wire logic tx_unlock_live,
    input wire logic tx_fault_flag,
    input wire logic tx_driver_shutoff_flag,
    input wire logic tx_detector_auto_enable,
    output logic [1:0] tx_rate_detect_mode,
    output logic tx_rate_auto,
    output logic tx_rate_fixed_10g3,
    output logic tx_rate_fixed_11g1,
    output logic tx_rate_test_mode,
    output logic tx_detector_enable,
    output logic tx_quick_lock_enable,
    output logic [2:0] tx_divider_sel,
    output logic [5:0] tx_divide_factor,
    output logic [2:0] loop_filter_res_sel,
    output logic irq
);

    // Synchronisers for the five pin flags.
    logic [4:0] pins_raw;
    logic [4:0] sync1_q;
    logic [4:0] sync2_q;
    logic [4:0] prev_q;
    logic [4:0] rise;

    assign pins_raw = {tx_driver_shutoff_flag, tx_fault_flag, tx_unlock_live,
                       rx_signal_loss_live, rx_unlock_live};

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            sync1_q <= IRQ_RESET;
            sync2_q <= IRQ_RESET;
            prev_q <= IRQ_RESET;
        end else begin
            sync1_q <= pins_raw;
            sync2_q <= sync1_q;
            prev_q <= sync2_q;
        end
    end

    assign rise = sync2_q & ~prev_q;

    logic rx_unlock_s;
    logic rx_loss_s;
    logic tx_unlock_s;
    logic tx_fault_s;
    logic tx_shutoff_s;

    assign rx_unlock_s = sync2_q[0];
    assign rx_loss_s = sync2_q[1];
    assign tx_unlock_s = sync2_q[2];
    assign tx_fault_s = sync2_q[3];
    assign tx_shutoff_s = sync2_q[4];

    function automatic logic addr_is(input logic [7:0] a, input logic [7:0] target);
        addr_is = (a == target);
    endfunction

    logic wr_ctl;
    logic wr_adj;
    logic wr_irq_en;
    logic wr_irq_clr;
    logic rd_rx_status;
    logic rd_tx_status;

    // Writes to reserved or read-only addresses decode to nothing.
    assign wr_ctl = reg_wr && addr_is(reg_addr, ADDR_TX_CDR_CONTROL);
    assign wr_adj = reg_wr && addr_is(reg_addr, ADDR_LOOP_FILTER_ADJUST);
    assign wr_irq_en = reg_wr && addr_is(reg_addr, ADDR_IRQ_ENABLE);
    assign wr_irq_clr = reg_wr && addr_is(reg_addr, ADDR_IRQ_CLEAR);
    assign rd_rx_status = reg_rd && addr_is(reg_addr, ADDR_RECEIVE_STATUS);
    assign rd_tx_status = reg_rd && addr_is(reg_addr, ADDR_TRANSMIT_STATUS);

    // Control register.
    logic [7:0] tx_cdr_control_q;

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            tx_cdr_control_q <= TX_CDR_CONTROL_RESET;
        end else if (wr_ctl) begin
            tx_cdr_control_q <= reg_wdata;
        end
    end

    // Adjustment register; only the resistor field is kept.
    logic [7:0] loop_filter_adjust_q;

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            loop_filter_adjust_q <= LOOP_FILTER_ADJUST_RESET;
        end else if (wr_adj) begin
            loop_filter_adjust_q <= reg_wdata & LOOP_FILTER_ADJUST_MASK;
        end
    end

    assign loop_filter_res_sel = loop_filter_adjust_q[LF_RES_HI:LF_RES_LO];

    // Rate detection mode decode.
    logic [1:0] mode;

    assign mode = {tx_cdr_control_q[CTL_MODE_HI], tx_cdr_control_q[CTL_MODE_LO]};
    assign tx_rate_detect_mode = mode;

    always_comb begin
        tx_rate_auto = 1'b0;
        tx_rate_fixed_10g3 = 1'b0;
        tx_rate_fixed_11g1 = 1'b0;
        tx_rate_test_mode = 1'b0;
        unique case (mode)
            MODE_AUTO: begin
                tx_rate_auto = 1'b1;
            end
            MODE_FIXED_10G3: begin
                tx_rate_fixed_10g3 = 1'b1;
            end
            MODE_FIXED_11G1: begin
                tx_rate_fixed_11g1 = 1'b1;
            end
            MODE_TEST: begin
                tx_rate_test_mode = 1'b1;
            end
        endcase
    end

    // Force-off wins over force-on, so a conflicting setting fails safe.
    always_comb begin
        if (tx_cdr_control_q[CTL_FORCE_OFF]) begin
            tx_detector_enable = 1'b0;
        end else if (tx_cdr_control_q[CTL_FORCE_ON]) begin
            tx_detector_enable = 1'b1;
        end else begin
            tx_detector_enable = tx_detector_auto_enable;
        end
    end

    assign tx_quick_lock_enable = ~tx_cdr_control_q[CTL_QUICK_LOCK_OFF];

    assign tx_divider_sel = tx_cdr_control_q[CTL_DIV_HI:CTL_DIV_LO];

    // Undefined codes above 101 fall back to full rate.
    always_comb begin
        if (tx_divider_sel <= DIV_LAST_CODE) begin
            tx_divide_factor = 6'(6'h01 << tx_divider_sel);
        end else begin
            tx_divide_factor = 6'h01;
        end
    end

    // Latched status bits; a read returns the held value and then reloads
    // from the live flag, so an event in the read cycle is never lost.
    logic rx_lock_sticky_low_q;
    logic rx_signal_loss_sticky_q;
    logic tx_lock_sticky_low_q;

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            rx_lock_sticky_low_q <= 1'b0;
        end else if (rd_rx_status) begin
            rx_lock_sticky_low_q <= rx_unlock_s;
        end else begin
            rx_lock_sticky_low_q <= rx_lock_sticky_low_q & rx_unlock_s;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            rx_signal_loss_sticky_q <= 1'b0;
        end else if (rd_rx_status) begin
            rx_signal_loss_sticky_q <= rx_loss_s;
        end else begin
            rx_signal_loss_sticky_q <= rx_signal_loss_sticky_q | rx_loss_s;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            tx_lock_sticky_low_q <= 1'b0;
        end else if (rd_tx_status) begin
            tx_lock_sticky_low_q <= tx_unlock_s;
        end else begin
            tx_lock_sticky_low_q <= tx_lock_sticky_low_q & tx_unlock_s;
        end
    end

    logic [7:0] receive_status;
    logic [7:0] transmit_status;

    always_comb begin
        receive_status = READ_ZERO;
        receive_status[ST_UNLOCK_LIVE] = rx_unlock_s;
        receive_status[ST_LOCK_STICKY] = rx_lock_sticky_low_q;
        receive_status[ST_BIT5] = rx_loss_s;
        receive_status[ST_BIT4] = rx_signal_loss_sticky_q;
    end

    always_comb begin
        transmit_status = READ_ZERO;
        transmit_status[ST_UNLOCK_LIVE] = tx_unlock_s;
        transmit_status[ST_LOCK_STICKY] = tx_lock_sticky_low_q;
        transmit_status[ST_BIT5] = tx_fault_s;
        transmit_status[ST_BIT4] = tx_shutoff_s;
    end

    // Interrupts: sticky on each rising flag, set wins over clear.
    logic [IRQ_COUNT-1:0] irq_status_q;
    logic [IRQ_COUNT-1:0] irq_enable_q;
    logic [IRQ_COUNT-1:0] irq_clear;

    assign irq_clear = wr_irq_clr ? reg_wdata[IRQ_COUNT-1:0] : IRQ_RESET;

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            irq_status_q <= IRQ_RESET;
        end else begin
            irq_status_q <= (irq_status_q & ~irq_clear) | rise;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            irq_enable_q <= IRQ_RESET;
        end else if (wr_irq_en) begin
            irq_enable_q <= reg_wdata[IRQ_COUNT-1:0];
        end
    end

    assign irq = |(irq_status_q & irq_enable_q);

    // Read port: data stand one cycle after the strobe and only then.
    logic [7:0] rdata_d;
    logic [7:0] reg_rdata_q;

    always_comb begin
        rdata_d = READ_ZERO;
        if (reg_rd) begin
            unique case (1'b1)
                addr_is(reg_addr, ADDR_TX_CDR_CONTROL): begin
                    rdata_d = tx_cdr_control_q;
                end
                addr_is(reg_addr, ADDR_ADC_RESULT_HIGH): begin
                    rdata_d = adc_result[9:2];
                end
                addr_is(reg_addr, ADDR_ADC_RESULT_LOW): begin
                    rdata_d = {6'h00, adc_result[1:0]};
                end
                addr_is(reg_addr, ADDR_RECEIVE_STATUS): begin
                    rdata_d = receive_status;
                end
                addr_is(reg_addr, ADDR_TRANSMIT_STATUS): begin
                    rdata_d = transmit_status;
                end
                addr_is(reg_addr, ADDR_LOOP_FILTER_ADJUST): begin
                    rdata_d = loop_filter_adjust_q;
                end
                addr_is(reg_addr, ADDR_IRQ_STATUS): begin
                    rdata_d = {3'h0, irq_status_q};
                end
                addr_is(reg_addr, ADDR_IRQ_ENABLE): begin
                    rdata_d = {3'h0, irq_enable_q};
                end
                default: begin
                    rdata_d = READ_ZERO;
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            reg_rdata_q <= READ_ZERO;
        end else begin
            reg_rdata_q <= rdata_d;
        end
    end

    assign reg_rdata = reg_rdata_q;

endmodule // cdr_status_control_regs

`default_nettype wire

// [test/cdr_regs_monitor.sv]
/* Port checker for the clock-recovery register bank.
   Assumes one clock domain and a synchronous active-high reset. */
`timescale 1ns/10ps
`default_nettype none
module cdr_regs_monitor
    import cdr_regs_pkg::*;
(
    input wire logic sys_clk,
    input wire logic srst,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_rdata,
    input wire logic [9:0] adc_result,
    input wire logic rx_signal_loss_live,
    input wire logic [1:0] tx_rate_detect_mode,
    input wire logic tx_rate_auto,
    input wire logic tx_rate_fixed_10g3,
    input wire logic tx_rate_fixed_11g1,
    input wire logic tx_rate_test_mode,
    input wire logic tx_detector_enable,
    input wire logic tx_quick_lock_enable,
    input wire logic [2:0] tx_divider_sel,
    input wire logic [5:0] tx_divide_factor,
    input wire logic [2:0] loop_filter_res_sel,
    input wire logic irq
);
    logic wr_ctl;
    assign wr_ctl = reg_wr && (reg_addr == ADDR_TX_CDR_CONTROL);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (srst);
    a_read_idle_zero: assert property (!reg_rd |=> reg_rdata == 8'h00)
        else $error("read data not zero outside read cycle");
    a_mode_decode: assert property (wr_ctl |=> tx_rate_detect_mode == $past(reg_wdata[7:6])
        && {tx_rate_test_mode, tx_rate_fixed_11g1, tx_rate_fixed_10g3, tx_rate_auto}
        == (4'h1 << $past(reg_wdata[7:6]))) else $error("mode decode wrong");
    a_force_off_wins: assert property (wr_ctl && reg_wdata[CTL_FORCE_OFF] |=> !tx_detector_enable)
        else $error("detector not held off");
    a_force_on_holds: assert property (wr_ctl && reg_wdata[5:4] == 2'h2 |=> tx_detector_enable)
        else $error("detector not held on");
    a_quick_lock_bit: assert property (wr_ctl |=> tx_quick_lock_enable == !$past(reg_wdata[3]))
        else $error("quick lock enable wrong");
    a_divider_code: assert property (wr_ctl |=> tx_divider_sel == $past(reg_wdata[2:0]))
        else $error("divider select wrong");
    a_divide_factor: assert property ($onehot(tx_divide_factor)
        && ((tx_divider_sel > DIV_LAST_CODE) ? (tx_divide_factor == 6'h01)
        : tx_divide_factor[tx_divider_sel])) else $error("divide factor wrong");
    a_adc_high_part: assert property (reg_rd && reg_addr == ADDR_ADC_RESULT_HIGH
        |=> reg_rdata == $past(adc_result[9:2])) else $error("result high byte wrong");
    a_adc_low_part: assert property (reg_rd && reg_addr == ADDR_ADC_RESULT_LOW
        |=> reg_rdata == {6'h00, $past(adc_result[1:0])}) else $error("result low byte wrong");
    a_reserved_reads: assert property (reg_rd && reg_addr inside
        {[ADDR_RSVD_A_FIRST:ADDR_RSVD_A_LAST], [ADDR_RSVD_B_FIRST:ADDR_RSVD_B_LAST]}
        |=> reg_rdata == 8'h00) else $error("reserved read not zero");
    // The pin passes two flops, so it must be steady three edges before the read.
    a_loss_live_bit: assert property (rx_signal_loss_live[*3] ##0 reg_rd
        && reg_addr == ADDR_RECEIVE_STATUS |=> reg_rdata[ST_BIT5]) else $error("loss bit low");
    a_adjust_reset: assert property ($fell(srst) |-> loop_filter_res_sel == 3'h2)
        else $error("adjust field reset wrong");
    a_irq_masked: assert property (reg_wr && reg_addr == ADDR_IRQ_ENABLE
        && reg_wdata[4:0] == 5'h00 |=> !irq) else $error("masked interrupt raised");
    c_ctl_write: cover property (wr_ctl);
    c_status_read: cover property (reg_rd && reg_addr == ADDR_RECEIVE_STATUS);
    c_irq_high: cover property (irq);
endmodule // cdr_regs_monitor

bind cdr_status_control_regs cdr_regs_monitor i_cdr_regs_monitor (
    .sys_clk, .srst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .adc_result,
    .rx_signal_loss_live, .tx_rate_detect_mode, .tx_rate_auto, .tx_rate_fixed_10g3,
    .tx_rate_fixed_11g1, .tx_rate_test_mode, .tx_detector_enable, .tx_quick_lock_enable,
    .tx_divider_sel, .tx_divide_factor, .loop_filter_res_sel, .irq
);
`default_nettype wire

// [test/cdr_status_control_regs_test.sv]
/* Self-checking bench for the clock-recovery register bank.
   Assumes the strobe register port and pins held steady for five cycles. */
`timescale 1ns/10ps
`default_nettype none
module cdr_status_control_regs_test;
    import cdr_regs_pkg::*;
    logic sys_clk = 1'b0;
    logic srst = 1'b1;
    logic [7:0] reg_addr = 8'h00;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [9:0] adc_result = 10'h000;
    logic rx_unlock_live = 1'b0;
    logic rx_signal_loss_live = 1'b0;
    logic tx_unlock_live = 1'b0;
    logic tx_fault_flag = 1'b0;
    logic tx_driver_shutoff_flag = 1'b0;
    logic tx_detector_auto_enable = 1'b0;
    logic [7:0] reg_rdata;
    logic [1:0] tx_rate_detect_mode;
    logic tx_rate_auto, tx_rate_fixed_10g3, tx_rate_fixed_11g1, tx_rate_test_mode;
    logic tx_detector_enable, tx_quick_lock_enable, irq;
    logic [2:0] tx_divider_sel, loop_filter_res_sel;
    logic [5:0] tx_divide_factor;
    logic [7:0] fv[4] = '{8'h10, 8'h20, 8'h30, 8'h08};
    logic [7:0] fe[4] = '{8'h01, 8'h03, 8'h01, 8'h02};
    logic [7:0] ra[5] = '{8'h14, 8'h27, 8'h2C, 8'h32, 8'hFF};
    int errors = 0;
    int cmp_count = 0;
    int cycles = 0;
    int i;

    cdr_status_control_regs i_cdr_status_control_regs (
        .sys_clk, .srst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .adc_result,
        .rx_unlock_live, .rx_signal_loss_live, .tx_unlock_live, .tx_fault_flag,
        .tx_driver_shutoff_flag, .tx_detector_auto_enable, .tx_rate_detect_mode,
        .tx_rate_auto, .tx_rate_fixed_10g3, .tx_rate_fixed_11g1, .tx_rate_test_mode,
        .tx_detector_enable, .tx_quick_lock_enable, .tx_divider_sel, .tx_divide_factor,
        .loop_filter_res_sel, .irq
    );

    always #10 sys_clk = ~sys_clk;

    task automatic finish_test();
        if (errors == 0 && cmp_count > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp) begin
            errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
        @(posedge sys_clk);
    endtask

    // Read data stand for one cycle only, so they are sampled just after the taking edge.
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1 chk(reg_rdata, exp);
        @(posedge sys_clk);
    endtask

    task automatic w5();
        repeat (5) @(posedge sys_clk);
    endtask

    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 5000) begin
            errors++;
            finish_test();
        end
    end

    initial begin
        repeat (5) @(posedge sys_clk);
        srst <= 1'b0;
        @(posedge sys_clk);
        rd(ADDR_TX_CDR_CONTROL, 8'h00);
        rd(ADDR_LOOP_FILTER_ADJUST, 8'h40);
        chk({5'h00, loop_filter_res_sel}, 8'h02);
        chk({6'h00, tx_rate_auto, tx_quick_lock_enable}, 8'h03);
        wr(ADDR_LOOP_FILTER_ADJUST, 8'hFF);
        rd(ADDR_LOOP_FILTER_ADJUST, 8'hE0);
        srst <= 1'b1;
        @(posedge sys_clk);
        srst <= 1'b0;
        @(posedge sys_clk);
        rd(ADDR_LOOP_FILTER_ADJUST, 8'h40);
        for (i = 0; i < 4; i++) begin
            wr(ADDR_TX_CDR_CONTROL, {i[1:0], 6'h00});
            chk({tx_rate_test_mode, tx_rate_fixed_11g1, tx_rate_fixed_10g3, tx_rate_auto,
                2'h0, tx_rate_detect_mode}, {4'h1 << i, 2'h0, i[1:0]});
        end
        for (i = 0; i < 8; i++) begin
            wr(ADDR_TX_CDR_CONTROL, i[7:0]);
            chk({2'h0, tx_divide_factor}, (i < 6) ? (8'h01 << i) : 8'h01);
        end
        tx_detector_auto_enable <= 1'b1;
        for (i = 0; i < 4; i++) begin
            wr(ADDR_TX_CDR_CONTROL, fv[i]);
            chk({6'h00, tx_detector_enable, tx_quick_lock_enable}, fe[i]);
        end
        tx_detector_auto_enable <= 1'b0;
        wr(ADDR_TX_CDR_CONTROL, 8'h00);
        chk({6'h00, tx_detector_enable, tx_quick_lock_enable}, 8'h01);
        for (i = 0; i < 5; i++) begin
            wr(ra[i], 8'hFF);
            rd(ra[i], 8'h00);
        end
        rd(ADDR_TX_CDR_CONTROL, 8'h00);
        adc_result <= 10'h2D6;
        wr(ADDR_ADC_RESULT_HIGH, 8'h00);
        rd(ADDR_ADC_RESULT_HIGH, 8'hB5);
        rd(ADDR_ADC_RESULT_LOW, 8'h02);
        wr(ADDR_IRQ_ENABLE, 8'h1F);
        rx_signal_loss_live <= 1'b1;
        w5();
        chk({7'h00, irq}, 8'h01);
        rd(ADDR_IRQ_STATUS, 8'h02);
        rd(ADDR_RECEIVE_STATUS, 8'h30);
        rx_signal_loss_live <= 1'b0;
        w5();
        rd(ADDR_RECEIVE_STATUS, 8'h10);
        rd(ADDR_RECEIVE_STATUS, 8'h00);
        wr(ADDR_IRQ_CLEAR, 8'h1F);
        chk({7'h00, irq}, 8'h00);
        rx_unlock_live <= 1'b1;
        w5();
        rd(ADDR_RECEIVE_STATUS, 8'h80);
        rd(ADDR_RECEIVE_STATUS, 8'hC0);
        rx_unlock_live <= 1'b0;
        w5();
        rx_unlock_live <= 1'b1;
        w5();
        rd(ADDR_RECEIVE_STATUS, 8'h80);
        wr(ADDR_IRQ_CLEAR, 8'h1F);
        wr(ADDR_IRQ_ENABLE, 8'h00);
        tx_fault_flag <= 1'b1;
        tx_driver_shutoff_flag <= 1'b1;
        tx_unlock_live <= 1'b1;
        w5();
        chk({7'h00, irq}, 8'h00);
        rd(ADDR_IRQ_STATUS, 8'h1C);
        wr(ADDR_IRQ_ENABLE, 8'h08);
        chk({7'h00, irq}, 8'h01);
        rd(ADDR_IRQ_ENABLE, 8'h08);
        rd(ADDR_TRANSMIT_STATUS, 8'hB0);
        rd(ADDR_TRANSMIT_STATUS, 8'hF0);
        tx_fault_flag <= 1'b0;
        tx_driver_shutoff_flag <= 1'b0;
        tx_unlock_live <= 1'b0;
        w5();
        rd(ADDR_TRANSMIT_STATUS, 8'h00);
        finish_test();
    end
endmodule // cdr_status_control_regs_test
`default_nettype wire
